// file: dv/prp_ctl_model.sv
// link-side controller model issuing register requests
`default_nettype none
module prp_ctl_model
   import prp_pkg::*;
(
   input wire logic clk_in,
   output var prp_req_t req_out
);
   initial req_out = '0; // idle from time zero
   // one request per call, moved only at the falling edge; idle calls give slow pacing
   task automatic put(input prp_req_t r);
      @(negedge clk_in);
      req_out = r;
   endtask
endmodule // prp_ctl_model
`default_nettype wire

// file: dv/prp_regs_assertions.sv
// port checker for the phy register paging block
`default_nettype none
module prp_regs_assertions
   import prp_pkg::*;
#(
   parameter int NUM_PAGES = PRP_NUM_PAGES
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire prp_req_t req_in,
   input wire prp_rsp_t rsp_out,
   input wire logic [PRP_PAGE_W-1:0] page_out
);
   // ----------------------------------------------------------------
   // sequences
   // ----------------------------------------------------------------
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence s_page_wr;
      req_in.wr && req_in.addr == PRP_PAGE_SEL_ADDR;
   endsequence
   sequence s_rd_sel;
      req_in.rd && req_in.addr == PRP_PAGE_SEL_ADDR;
   endsequence
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_rd_ans; req_in.rd |=> rsp_out.valid; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   property p_no_ans; !req_in.rd |=> !rsp_out.valid; endproperty
   a_no_ans: assert property (p_no_ans) else $error("answer without read");
   property p_idle_zero; !rsp_out.valid |-> rsp_out.rdata == PRP_ZERO; endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("data while idle");
   property p_page_set; s_page_wr |=> page_out == $past(req_in.wdata[7:5]); endproperty
   a_page_set: assert property (p_page_set) else $error("page not taken");
   property p_page_hold; !(req_in.wr && req_in.addr == PRP_PAGE_SEL_ADDR) |=> $stable(page_out); endproperty
   a_page_hold: assert property (p_page_hold) else $error("page moved");
   property p_rsvd_page; req_in.rd && req_in.addr[3] && page_out inside {[2:6]} |=> rsp_out.rdata == PRP_ZERO;
   endproperty
   a_rsvd_page: assert property (p_rsvd_page) else $error("reserved page data");
   property p_rsvd_bit; s_rd_sel |=> !rsp_out.rdata[4]; endproperty
   a_rsvd_bit: assert property (p_rsvd_bit) else $error("reserved bit set");
   property p_sel_read; s_rd_sel |=> rsp_out.rdata[7:5] == $past(page_out); endproperty
   a_sel_read: assert property (p_sel_read) else $error("page field wrong");
endmodule // prp_regs_assertions
`default_nettype wire

// file: dv/tb_top.sv
// top-level bench for the phy register paging block
`default_nettype none
`define CHK(n, e, g) cmp_count++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", n, e, g); end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import prp_pkg::*;
   localparam logic [1:0] NO = 2'h0, WR = 2'h1, RD = 2'h2, RW = 2'h3; // {rd,wr} codes
   logic clk_in;
   logic rst_in;
   prp_req_t req_in;
   prp_rsp_t rsp_out;
   logic [PRP_PAGE_W-1:0] page_out;
   int n_errors = 0;
   int cmp_count = 0;
   // rows: {rd,wr}, address, write data, expected read data
   logic [21:0] rows [23] = '{
      {WR, 4'h7, 8'h00, 8'h00}, {WR, 4'h8, 8'hA5, 8'h00}, {WR, 4'h0, 8'h3C, 8'h00},
      {WR, 4'h7, 8'h20, 8'h00}, {WR, 4'h8, 8'h5A, 8'h00}, {RD, 4'h8, 8'h00, 8'h5A},
      {RD, 4'h0, 8'h00, 8'h3C}, {RD, 4'h7, 8'h00, 8'h20}, {WR, 4'h7, 8'h00, 8'h00},
      {RD, 4'h8, 8'h00, 8'hA5}, {RW, 4'h9, 8'h33, 8'h00}, {RD, 4'h9, 8'h00, 8'h33},
      {WR, 4'h7, 8'hFF, 8'h00}, {RD, 4'h7, 8'h00, 8'hEF}, {WR, 4'hF, 8'h77, 8'h00},
      {RD, 4'hF, 8'h00, 8'h77}, {WR, 4'h7, 8'h40, 8'h00}, {WR, 4'h8, 8'h11, 8'h00},
      {RD, 4'h8, 8'h00, 8'h00}, {RD, 4'h0, 8'h00, 8'h3C}, {WR, 4'h7, 8'h00, 8'h00},
      {RD, 4'h8, 8'h00, 8'hA5}, {NO, 4'h0, 8'h00, 8'h00}};
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   prp_ctl_model ctl (.clk_in(clk_in), .req_out(req_in));
   prp_regs #(.NUM_PAGES(PRP_NUM_PAGES)) uut (.clk_in(clk_in), .rst_in(rst_in), .req_in(req_in),
      .rsp_out(rsp_out), .page_out(page_out));
   // ----------------------------------------------------------------
   // verdict
   // ----------------------------------------------------------------
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog: the whole run needs well under 200 cycles
   initial begin
      #20000;
      n_errors++;
      close_out();
   end
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      rst_in = 1'b1;
      repeat (8) @(posedge clk_in);
      @(negedge clk_in);
      rst_in = 1'b0;
      `CHK("page", 3'h0, page_out)
      `CHK("rsp", 9'h000, rsp_out)
      $display("test reset done");
      // back to back, one row per cycle; a read is judged one cycle later
      for (int i = 0; i < 23; i++) begin
         ctl.put(rows[i][21:8]);
         if (i > 0 && rows[i-1][21]) begin
            `CHK("rdata", rows[i-1][7:0], rsp_out.rdata)
            `CHK("valid", 1'b1, rsp_out.valid)
         end
      end
      $display("test table done");
      // pages 3 to 6 hide even the page 7 data at address F
      for (int p = 3; p < 7; p++) begin
         ctl.put({WR, 4'h7, 3'(p), 5'h00});
         ctl.put({RD, 4'hF, 8'h00});
         ctl.put('0);
         `CHK("rsvd", 9'h100, rsp_out)
         `CHK("page", 3'(p), page_out)
      end
      $display("test reserved pages done");
      // reset in mid-run with a read pending clears page and storage
      ctl.put({WR, 4'h7, 8'hE0});
      ctl.put({RD, 4'h8, 8'h00});
      rst_in = 1'b1;
      @(negedge clk_in);
      `CHK("page", 3'h0, page_out)
      `CHK("rsp", 9'h000, rsp_out)
      rst_in = 1'b0;
      ctl.put({RD, 4'h8, 8'h00});
      ctl.put('0);
      `CHK("rsp", 9'h100, rsp_out)
      $display("test mid reset done");
      close_out();
   end
endmodule // tb_top
bind prp_regs prp_regs_assertions #(.NUM_PAGES(NUM_PAGES)) chk (.clk_in(clk_in), .rst_in(rst_in),
   .req_in(req_in), .rsp_out(rsp_out), .page_out(page_out));
`default_nettype wire

// file: logic/prp_mem.sv
// small register storage with registered read data
`default_nettype none
module prp_mem
   import prp_pkg::*;
#(
   parameter int DEPTH = 8,
   parameter int AW = 3,
   parameter int DW = 8
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic wr_in,
   input wire logic [AW-1:0] waddr_in,
   input wire logic [DW-1:0] wdata_in,
   input wire logic [AW-1:0] raddr_in,
   output logic [DW-1:0] rdata_out
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [DEPTH-1:0][DW-1:0] mem;   // storage words
      logic [DW-1:0] rd;               // registered read data
   } prp_mem_st_t;

   prp_mem_st_t st_r;   // current state
   prp_mem_st_t st_nxt; // next state

   // write and read; read shows the old word on a same-cycle write
   always_comb begin
      st_nxt = st_r;
      st_nxt.rd = st_r.mem[raddr_in];
      if (wr_in) begin
         st_nxt.mem[waddr_in] = wdata_in;
      end
   end

   // register the state
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata_out = st_r.rd;
endmodule // prp_mem
`default_nettype wire

// file: logic/prp_pkg.sv
// package of constants and carrier types for the phy register paging block
`default_nettype none
package prp_pkg;
   // ----------------------------------------------------------------
   // address map
   // ----------------------------------------------------------------
   localparam int PRP_ADDR_W = 4;                         // register address width
   localparam int PRP_DATA_W = 8;                         // register data width
   localparam int PRP_NUM_REGS = 16;                      // total reachable registers
   localparam int PRP_NUM_BASE = 8;                       // base registers at low addresses
   localparam int PRP_NUM_PAGES = 8;                      // page count for the paged range
   localparam int PRP_PAGE_W = 3;                         // page number width
   localparam int PRP_IDX_W = 3;                          // index within base or paged range
   localparam logic [3:0] PRP_PAGE_SEL_ADDR = 4'h7;       // base register holding page select
   localparam int PRP_PAGE_MSB = 7;                       // page field top bit in base reg 7
   localparam int PRP_PAGE_LSB = 5;                       // page field low bit in base reg 7
   localparam logic [7:0] PRP_PAGE_REG_MASK = 8'hEF;      // bit 4 of reg 7 is reserved
   localparam logic [7:0] PRP_RESET_VAL = 8'h00;          // reset value of writable storage
   localparam logic [7:0] PRP_ZERO = 8'h00;               // reserved read value
   localparam logic [2:0] PRP_RSVD_PAGE_LO = 3'h2;        // first reserved page
   localparam logic [2:0] PRP_RSVD_PAGE_HI = 3'h6;        // last reserved page

   // register access request from the controller side
   typedef struct packed {
      logic rd;                  // read strobe
      logic wr;                  // write strobe
      logic [3:0] addr;          // register address
      logic [7:0] wdata;         // write data
   } prp_req_t;

   // read answer
   typedef struct packed {
      logic valid;               // read data valid pulse
      logic [7:0] rdata;         // read data
   } prp_rsp_t;
endpackage
`default_nettype wire

// file: logic/prp_regs.sv
// top of the phy register paging block: decode, page select, paged banks
`default_nettype none
module prp_regs
   import prp_pkg::*;
#(
   parameter int NUM_PAGES = PRP_NUM_PAGES
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire prp_req_t req_in,
   output prp_rsp_t rsp_out,
   output logic [PRP_PAGE_W-1:0] page_out
);
   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // pages two to six hold no registers
   function automatic logic prp_page_rsvd(input logic [PRP_PAGE_W-1:0] pg);
      prp_page_rsvd = (pg >= PRP_RSVD_PAGE_LO) && (pg <= PRP_RSVD_PAGE_HI);
   endfunction

   // upper half of the range is paged
   function automatic logic prp_is_paged(input logic [PRP_ADDR_W-1:0] a);
      prp_is_paged = a[PRP_ADDR_W-1];
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [PRP_PAGE_W-1:0] page;     // selected page
      logic rd_paged;                  // pending read went to paged range
      logic rd_rsvd;                   // pending read hits a reserved page
      logic rd_v;                      // read answer valid
      logic [PRP_IDX_W-1:0] rd_idx;    // read index
   } prp_st_t;

   prp_st_t st_r;   // current state
   prp_st_t st_nxt; // next state

   logic [PRP_DATA_W-1:0] base_rd;     // base bank read data
   logic [NUM_PAGES-1:0][PRP_DATA_W-1:0] page_rd; // paged bank read data
   logic [PRP_IDX_W-1:0] idx;          // low address bits
   logic [PRP_DATA_W-1:0] rdata;       // assembled read data

   assign idx = req_in.addr[PRP_IDX_W-1:0];

   // ----------------------------------------------------------------
   // base bank: fixed layout, never indexed by page
   // ----------------------------------------------------------------
   prp_mem #(
      .DEPTH(PRP_NUM_BASE),
      .AW(PRP_IDX_W),
      .DW(PRP_DATA_W)
   ) u_base (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .wr_in(req_in.wr && !prp_is_paged(req_in.addr)),
      .waddr_in(idx),
      .wdata_in(req_in.wdata & ((req_in.addr == PRP_PAGE_SEL_ADDR) ? PRP_PAGE_REG_MASK : 8'hFF)),
      .raddr_in(idx),
      .rdata_out(base_rd)
   );

   // ----------------------------------------------------------------
   // paged banks, one per page; reserved pages get no storage
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_PAGES; g++) begin : g_page
         if ((g >= PRP_RSVD_PAGE_LO) && (g <= PRP_RSVD_PAGE_HI)) begin : g_rsvd
            assign page_rd[g] = PRP_ZERO;
         end else begin : g_bank
            prp_mem #(
               .DEPTH(PRP_NUM_BASE),
               .AW(PRP_IDX_W),
               .DW(PRP_DATA_W)
            ) u_bank (
               .clk_in(clk_in),
               .rst_in(rst_in),
               .wr_in(req_in.wr && prp_is_paged(req_in.addr) && (st_r.page == PRP_PAGE_W'(g))),
               .waddr_in(idx),
               .wdata_in(req_in.wdata),
               .raddr_in(idx),
               .rdata_out(page_rd[g])
            );
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // next state: page select and read tracking
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.rd_v = req_in.rd;
      // capture routing for the read issued this cycle
      if (req_in.rd) begin
         st_nxt.rd_paged = prp_is_paged(req_in.addr);
         st_nxt.rd_rsvd = prp_page_rsvd(st_r.page);
         st_nxt.rd_idx = idx;
      end
      // page changes only by a write to base register 7
      if (req_in.wr && (req_in.addr == PRP_PAGE_SEL_ADDR)) begin
         st_nxt.page = req_in.wdata[PRP_PAGE_MSB:PRP_PAGE_LSB];
      end
   end

   // register the state
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // read data mux; the page used is the one in force at the request,
   // so a write to register 7 and a paged read in one cycle see the old page
   // ----------------------------------------------------------------
   logic [PRP_PAGE_W-1:0] rd_page_r; // page latched with the read
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_page_r <= '0;
      end else if (req_in.rd) begin
         rd_page_r <= st_r.page;
      end
   end

   always_comb begin
      if (!st_r.rd_paged) begin
         rdata = base_rd;
      end else if (st_r.rd_rsvd) begin
         rdata = PRP_ZERO;
      end else begin
         rdata = page_rd[rd_page_r];
      end
   end

   // answer: data from flip-flops, zero outside a valid cycle
   assign rsp_out.valid = st_r.rd_v;
   assign rsp_out.rdata = st_r.rd_v ? rdata : PRP_ZERO;
   assign page_out = st_r.page;
endmodule // prp_regs
`default_nettype wire
